/* hdl/cfa_map.svh */
`ifndef CFA_MAP_SVH
`define CFA_MAP_SVH
`define CFA_RESET_FETCH   16'h0000
`define CFA_IO_TOP        16'h0FFF
`define CFA_IO_LOW_TOP    16'h003F
`define CFA_IO_BIT_TOP    16'h001F
`define CFA_NVM_BASE      16'h1000
`define CFA_SRAM_BASE     16'h1800
`define CFA_FLASH_BASE    16'h8000
`define CFA_IO_SPL        16'h003D
`define CFA_IO_SPH        16'h003E
`define CFA_IO_FLAGS      16'h003F
`define CFA_MUL_CYCLES    2
`define CFA_PTR_X         5'h1A
`define CFA_PTR_Y         5'h1C
`define CFA_PTR_Z         5'h1E
`define CFA_FLAG_C        0
`define CFA_FLAG_Z        1
`define CFA_FLAG_N        2
`define CFA_FLAG_V        3
`define CFA_FLAG_S        4
`define CFA_FLAG_H        5
`endif

/* hdl/cfa_pkg.sv */
`default_nettype none
package cfa_pkg;
   // execute-stage operation codes
   typedef enum logic [4:0] {
      CFA_OP_NOP, CFA_OP_ADD, CFA_OP_ADC, CFA_OP_SUB, CFA_OP_SBC, CFA_OP_AND,
      CFA_OP_OR, CFA_OP_EOR, CFA_OP_MOV, CFA_OP_LSR, CFA_OP_ADIW, CFA_OP_SBIW,
      CFA_OP_MUL, CFA_OP_LOAD, CFA_OP_STORE, CFA_OP_IO_BIT, CFA_OP_IO_SKIP,
      CFA_OP_PGM_LOAD, CFA_OP_JUMP, CFA_OP_CALL, CFA_OP_RET
   } cfa_op_t;
   // multiply formats: signedness of each side and fractional shift
   typedef struct packed {
      logic sign_a;
      logic sign_b;
      logic frac;
   } cfa_mul_mode_t;
   // data-space addressing modes
   typedef enum logic [2:0] {
      CFA_AM_DIRECT, CFA_AM_INDIRECT, CFA_AM_DISP, CFA_AM_POSTINC, CFA_AM_PREDEC
   } cfa_amode_t;
   // decoded instruction from the external decoder
   typedef struct packed {
      cfa_op_t       op;
      logic [4:0]    rd;
      logic [4:0]    rr;
      logic          use_imm;
      logic [7:0]    imm;
      cfa_mul_mode_t mul;
      cfa_amode_t    amode;
      logic [1:0]    ptr;
      logic [5:0]    disp;
      logic [15:0]   addr;
      logic [2:0]    bit_sel;
      logic          bit_val;
      logic          two_word;
   } cfa_dec_t;
   // data bus request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } cfa_dreq_t;
   // data-space region decode
   typedef struct packed {
      logic io_low;
      logic io_ext;
      logic nvm;
      logic sram;
      logic flash;
   } cfa_region_t;
endpackage
`default_nettype wire

/* hdl/cfa_mul.sv */
`include "cfa_map.svh"
`default_nettype none
module cfa_mul
   import cfa_pkg::*;
(
   // clock and reset
   input  wire logic          clk_sys,
   input  wire logic          sys_rst,
   // request
   input  wire logic          start,
   input  wire cfa_mul_mode_t mode,
   input  wire logic [7:0]    op_a,
   input  wire logic [7:0]    op_b,
   // result
   output logic               done,
   output logic [15:0]        product,
   output logic               carry
);
   logic [8:0]  ext_a;
   logic [8:0]  ext_b;
   logic [17:0] full;
   logic [15:0] raw;
   logic [15:0] stage;
   logic        stage_carry;
   logic        busy;
   // sign-extend each operand according to its mode
   assign ext_a = {mode.sign_a & op_a[7], op_a};
   assign ext_b = {mode.sign_b & op_b[7], op_b};
   assign full  = $signed(ext_a) * $signed(ext_b);
   assign raw   = full[15:0];
   // first cycle captures, second cycle presents the product
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         busy        <= 1'b0;
         stage       <= 16'h0000;
         stage_carry <= 1'b0;
      end
      else
      begin
         busy        <= start & ~busy;
         stage       <= mode.frac ? {raw[14:0], 1'b0} : raw;
         stage_carry <= raw[15];
      end
   end
   // result registered on the second edge
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         done    <= 1'b0;
         product <= 16'h0000;
         carry   <= 1'b0;
      end
      else
      begin
         done <= busy;
         if (busy)
         begin
            product <= stage;
            carry   <= stage_carry;
         end
      end
   end
endmodule // cfa_mul
`default_nettype wire

/* hdl/cfa_core.sv */
// Behaviour
// - separate program and data buses
// - fetch next word while executing current
// - 32 byte registers, one-cycle ALU
// - three register pairs form pointers
// - ALU operations update flags, except MOV and loads
// - multiplier signed, unsigned, mixed, fractional
// - multiply takes exactly two cycles
// - fetch starts at zero after reset
// - one- and two-word instructions, full reach
// - return address pushed as word pointer
// - stack pointer resets high, written via I/O, loads do not return it
// - runs on undivided core clock
// - I/O in lowest 4KB, low 64 direct
// - bit set, clear, test in low 32
// - extended I/O only via load/store
// - NVM block and SRAM regions decoded
// - Flash mapped from 0x8000 in data
// - program load uses code-space addresses
// - flags not saved on interrupt entry
// - five data addressing modes
// - call pushes two bytes, low high
`include "cfa_map.svh"
`default_nettype none
module cfa_core
   import cfa_pkg::*;
#(
   parameter logic [15:0] SRAM_TOP = 16'h3FFF
)(
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   // program bus
   output logic [15:0]       fetch_addr,
   input  wire logic [15:0]  fetch_word,
   output logic [15:0]       pgm_addr,
   input  wire logic [15:0]  pgm_word,
   // decoded instruction
   input  wire cfa_dec_t     dec,
   input  wire logic         dec_valid,
   // data bus
   output cfa_dreq_t         dreq,
   output cfa_region_t       dregion,
   input  wire logic [7:0]   drdata,
   // state
   output logic [7:0]        alu_status_flags,
   output logic [15:0]       stack_pointer,
   output logic [15:0]       fetch_word_held,
   output logic              stall
);
   import cfa_pkg::*;
   logic [7:0]  regs [32];
   logic [15:0] next_fetch_address;
   logic [15:0] next_pc;
   logic [1:0]  push_step;
   logic [15:0] ret_word;
   logic        mul_busy;
   logic        mul_done;
   logic [15:0] mul_prod;
   logic        mul_carry;
   logic        skip;
   logic        pop_step;
   logic [7:0]  ret_hi;
   logic [7:0]  a;
   logic [7:0]  b;
   logic [8:0]  sum;
   logic [7:0]  res;
   logic        cin;
   logic        is_sub;
   logic        writes_rd;
   logic [7:0]  next_flags;
   logic [15:0] ptr_val;
   logic [16:0] word_res;
   logic [15:0] ea;
   logic [4:0]  ptr_lo;
   logic        exec;
   logic        io_hit;
   logic [7:0]  io_rd;
   logic        sp_wr_lo;
   logic        sp_wr_hi;
   logic        flag_wr;
   logic [15:0] ptr_inc;
   logic [15:0] z_val;
   logic [4:0]  nib;
   logic        is_logic;
   assign exec = dec_valid & ~stall & ~skip;
   // decoded operands, immediate or register
   assign a      = regs[dec.rd];
   assign b      = dec.use_imm ? dec.imm : regs[dec.rr];
   assign is_sub = dec.op == CFA_OP_SUB || dec.op == CFA_OP_SBC;
   assign cin    = (dec.op == CFA_OP_ADC || dec.op == CFA_OP_SBC) & alu_status_flags[`CFA_FLAG_C];
   assign sum    = is_sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
                          : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
   // low nibble carry or borrow for the half-carry flag
   assign nib      = is_sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin})
                            : ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
   assign is_logic = dec.op inside {CFA_OP_AND, CFA_OP_OR, CFA_OP_EOR};
   // one-cycle byte ALU result
   always_comb
   begin
      unique case (dec.op)
         CFA_OP_AND:  res = a & b;
         CFA_OP_OR:   res = a | b;
         CFA_OP_EOR:  res = a ^ b;
         CFA_OP_MOV:  res = b;
         CFA_OP_LSR:  res = {1'b0, a[7:1]};
         CFA_OP_LOAD: res = drdata;
         CFA_OP_PGM_LOAD: res = regs[`CFA_PTR_Z][0] ? pgm_word[15:8] : pgm_word[7:0];
         default:     res = sum[7:0];
      endcase
   end
   assign writes_rd = dec.op inside {CFA_OP_ADD, CFA_OP_ADC, CFA_OP_SUB, CFA_OP_SBC,
                      CFA_OP_AND, CFA_OP_OR, CFA_OP_EOR, CFA_OP_MOV, CFA_OP_LSR,
                      CFA_OP_LOAD, CFA_OP_PGM_LOAD};
   // pointer pairs X, Y, Z with low byte at the lower index
   assign ptr_lo   = dec.ptr == 2'd0 ? `CFA_PTR_X : dec.ptr == 2'd1 ? `CFA_PTR_Y : `CFA_PTR_Z;
   assign ptr_val  = {regs[ptr_lo + 5'd1], regs[ptr_lo]};
   assign ptr_inc  = ptr_val + 16'h0001;
   assign z_val    = {regs[`CFA_PTR_Z + 5'd1], regs[`CFA_PTR_Z]};
   assign word_res = dec.op == CFA_OP_SBIW ? {1'b0, {regs[dec.rd + 5'd1], a}} - {9'h000, b}
                                           : {1'b0, {regs[dec.rd + 5'd1], a}} + {9'h000, b};
   // effective data address per addressing mode
   always_comb
   begin
      unique case (dec.amode)
         CFA_AM_DIRECT:  ea = dec.addr;
         CFA_AM_DISP:    ea = ptr_val + {10'h000, dec.disp};
         CFA_AM_PREDEC:  ea = ptr_val - 16'h0001;
         default:        ea = ptr_val;
      endcase
   end
   // data-space region decode
   assign dregion.io_low = ea <= `CFA_IO_LOW_TOP;
   assign dregion.io_ext = ea > `CFA_IO_LOW_TOP && ea <= `CFA_IO_TOP;
   assign dregion.nvm    = ea >= `CFA_NVM_BASE && ea < `CFA_SRAM_BASE;
   assign dregion.sram   = ea >= `CFA_SRAM_BASE && ea < `CFA_FLASH_BASE;
   assign dregion.flash  = ea >= `CFA_FLASH_BASE;
   // core-local I/O: stack pointer bytes and flags
   assign io_hit   = ea == `CFA_IO_SPL || ea == `CFA_IO_SPH || ea == `CFA_IO_FLAGS;
   assign io_rd    = ea == `CFA_IO_SPL ? stack_pointer[7:0]
                   : ea == `CFA_IO_SPH ? stack_pointer[15:8] : alu_status_flags;
   assign sp_wr_lo = exec && dec.op == CFA_OP_STORE && ea == `CFA_IO_SPL;
   assign sp_wr_hi = exec && dec.op == CFA_OP_STORE && ea == `CFA_IO_SPH;
   assign flag_wr  = exec && dec.op == CFA_OP_STORE && ea == `CFA_IO_FLAGS;
   // data bus request: loads, stores, I/O bit ops, stack pushes and pops
   always_comb
   begin
      dreq = '0;
      if (push_step != 2'd0)
      begin
         dreq.wr    = 1'b1;
         dreq.addr  = stack_pointer;
         dreq.wdata = push_step == 2'd1 ? ret_word[7:0] : ret_word[15:8];
      end
      else if (pop_step)
      begin
         dreq.rd   = 1'b1;
         dreq.addr = stack_pointer;
      end
      else if (exec)
      begin
         unique case (dec.op)
            CFA_OP_LOAD:  begin dreq.rd = ~io_hit; dreq.addr = ea; end
            CFA_OP_STORE: begin dreq.wr = ~io_hit; dreq.addr = ea; dreq.wdata = a; end
            CFA_OP_RET:   begin dreq.rd = 1'b1; dreq.addr = stack_pointer + 16'h0001; end
            CFA_OP_IO_BIT:
            begin
               dreq.rd    = dec.addr <= `CFA_IO_BIT_TOP;
               dreq.wr    = dec.addr <= `CFA_IO_BIT_TOP;
               dreq.addr  = dec.addr;
               dreq.wdata = dec.bit_val ? drdata | (8'h01 << dec.bit_sel)
                                        : drdata & ~(8'h01 << dec.bit_sel);
            end
            CFA_OP_IO_SKIP:
            begin
               dreq.rd   = dec.addr <= `CFA_IO_BIT_TOP;
               dreq.addr = dec.addr;
            end
            default: dreq = '0;
         endcase
      end
   end
   // program-memory load addresses Flash from code address zero
   assign pgm_addr   = {1'b0, z_val[15:1]};
   assign fetch_addr = next_fetch_address;
   assign stall      = mul_busy | (push_step != 2'd0) | pop_step;
   // next fetch address selection
   always_comb
   begin
      next_pc = next_fetch_address + 16'h0001;
      if (exec && (dec.op == CFA_OP_JUMP || dec.op == CFA_OP_CALL))
         next_pc = dec.addr;
      else if (exec && dec.two_word)
         next_pc = next_fetch_address + 16'h0002;
      else if (pop_step)
         next_pc = {ret_hi, drdata};
      else if (stall)
         next_pc = next_fetch_address;
   end
   // flags per instruction class; interrupt entry never stores them
   always_comb
   begin
      next_flags = alu_status_flags;
      if (exec && writes_rd && dec.op != CFA_OP_MOV && dec.op != CFA_OP_LOAD
          && dec.op != CFA_OP_PGM_LOAD)
      begin
         next_flags[`CFA_FLAG_Z] = res == 8'h00;
         next_flags[`CFA_FLAG_N] = res[7];
         next_flags[`CFA_FLAG_C] = dec.op == CFA_OP_LSR ? a[0]
                                 : is_logic ? alu_status_flags[`CFA_FLAG_C] : sum[8];
         next_flags[`CFA_FLAG_V] = is_logic ? 1'b0 : dec.op == CFA_OP_LSR ? a[0]
                                 : is_sub ? (a[7] ^ b[7]) & (a[7] ^ res[7])
                                 : ~(a[7] ^ b[7]) & (a[7] ^ res[7]);
         next_flags[`CFA_FLAG_H] = is_logic || dec.op == CFA_OP_LSR
                                 ? alu_status_flags[`CFA_FLAG_H] : nib[4];
         next_flags[`CFA_FLAG_S] = next_flags[`CFA_FLAG_N] ^ next_flags[`CFA_FLAG_V];
      end
      else if (exec && (dec.op == CFA_OP_ADIW || dec.op == CFA_OP_SBIW))
      begin
         next_flags[`CFA_FLAG_Z] = word_res[15:0] == 16'h0000;
         next_flags[`CFA_FLAG_N] = word_res[15];
         next_flags[`CFA_FLAG_C] = word_res[16];
      end
      else if (mul_done)
      begin
         next_flags[`CFA_FLAG_C] = mul_carry;
         next_flags[`CFA_FLAG_Z] = mul_prod == 16'h0000;
      end
      else if (flag_wr)
         next_flags = a;
   end
   // multiplier, two cycles from start to result
   cfa_mul u_mul (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .start   (exec && dec.op == CFA_OP_MUL),
      .mode    (dec.mul),
      .op_a    (a),
      .op_b    (b),
      .done    (mul_done),
      .product (mul_prod),
      .carry   (mul_carry)
   );
   // fetch, flags and sequence state; clock used without division
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         next_fetch_address <= `CFA_RESET_FETCH;
         alu_status_flags   <= 8'h00;
         fetch_word_held    <= 16'h0000;
         mul_busy           <= 1'b0;
         skip               <= 1'b0;
         pop_step           <= 1'b0;
         ret_hi             <= 8'h00;
      end
      else
      begin
         next_fetch_address <= next_pc;
         alu_status_flags   <= next_flags;
         fetch_word_held    <= fetch_word;
         mul_busy           <= exec && dec.op == CFA_OP_MUL ? 1'b1 : mul_done ? 1'b0 : mul_busy;
         skip               <= exec && dec.op == CFA_OP_IO_SKIP
                               && dec.addr <= `CFA_IO_BIT_TOP
                               && drdata[dec.bit_sel] == dec.bit_val;
         pop_step           <= exec && dec.op == CFA_OP_RET;
         ret_hi             <= exec && dec.op == CFA_OP_RET ? drdata : ret_hi;
      end
   end
   // stack pointer: two-byte push on calls, pop by two on return
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         stack_pointer <= SRAM_TOP;
         push_step     <= 2'd0;
         ret_word      <= 16'h0000;
      end
      else
      begin
         if (exec && dec.op == CFA_OP_CALL)
         begin
            push_step <= 2'd1;
            ret_word  <= next_fetch_address + {15'h0000, dec.two_word};
         end
         else if (push_step == 2'd1)
            push_step <= 2'd2;
         else
            push_step <= 2'd0;
         if (push_step != 2'd0)
            stack_pointer <= stack_pointer - 16'h0001;
         else if (exec && dec.op == CFA_OP_RET)
            stack_pointer <= stack_pointer + 16'h0002;
         else if (sp_wr_lo)
            stack_pointer <= {stack_pointer[15:8], a};
         else if (sp_wr_hi)
            stack_pointer <= {a, stack_pointer[7:0]};
      end
   end
   // register file writes, byte, word and product
   always_ff @(posedge clk_sys)
   begin
      if (exec && writes_rd)
         regs[dec.rd] <= res;
      else if (exec && (dec.op == CFA_OP_ADIW || dec.op == CFA_OP_SBIW))
      begin
         regs[dec.rd]        <= word_res[7:0];
         regs[dec.rd + 5'd1] <= word_res[15:8];
      end
      else if (mul_done)
      begin
         regs[5'd0] <= mul_prod[7:0];
         regs[5'd1] <= mul_prod[15:8];
      end
      if (exec && (dec.amode == CFA_AM_POSTINC || dec.amode == CFA_AM_PREDEC)
          && (dec.op == CFA_OP_LOAD || dec.op == CFA_OP_STORE))
      begin
         regs[ptr_lo]        <= dec.amode == CFA_AM_POSTINC ? ptr_inc[7:0] : ea[7:0];
         regs[ptr_lo + 5'd1] <= dec.amode == CFA_AM_POSTINC ? ptr_inc[15:8] : ea[15:8];
      end
   end
   // reset fetch address lands at zero
   reset_fetch_a : assert property (@(posedge clk_sys) $fell(sys_rst) |->
      fetch_addr == `CFA_RESET_FETCH) else $error("fetch not at zero");
   mul_two_cycle_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      exec && dec.op == CFA_OP_MUL |-> ##2 mul_done) else $error("multiply not two cycles");
   sp_reset_a : assert property (@(posedge clk_sys) $fell(sys_rst) |->
      stack_pointer == SRAM_TOP) else $error("stack pointer reset wrong");
   call_push_two_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      exec && dec.op == CFA_OP_CALL |=> ##2 stack_pointer == $past(stack_pointer, 3) - 16'h0002)
      else $error("call did not push two");
   flash_map_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      dregion.flash |-> ea[15]) else $error("flash region misdecoded");
   seq_fetch_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      !stall && !exec |=> fetch_addr == $past(fetch_addr) + 16'h0001)
      else $error("fetch did not advance");
   io_ext_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      dregion.io_ext |-> ea > `CFA_IO_LOW_TOP && !dregion.io_low) else $error("I/O decode");
   zero_flag_a : assert property (@(posedge clk_sys) disable iff (sys_rst)
      exec && dec.op == CFA_OP_AND |=> alu_status_flags[`CFA_FLAG_Z] == ($past(res) == 8'h00))
      else $error("zero flag wrong");
endmodule // cfa_core
`default_nettype wire

/* tb/cfa_mem_model.sv */
`default_nettype none
module cfa_mem_model
   import cfa_pkg::*;
(
   // clock
   input  wire logic         clk_sys,
   // program bus
   input  wire logic [15:0]  fetch_addr,
   output logic [15:0]       fetch_word,
   input  wire logic [15:0]  pgm_addr,
   output logic [15:0]       pgm_word,
   // data bus
   input  wire cfa_dreq_t    dreq,
   output logic [7:0]        drdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] pmem [0:255];
   logic [7:0]  dmem [0:65535];
   logic [7:0]  last;
   logic [15:0] fword;
   logic [7:0]  dbyte;

   // counting pattern in program memory
   initial
   begin
      for (int i = 0; i < 256; i++) pmem[i] = 16'(i * 3 + 1);
      last = 8'h00;
   end

   // fetch and program-load ports answer independently of data
   assign fetch_word = pmem[fetch_addr[7:0]];
   assign pgm_word   = pmem[pgm_addr[7:0]];
   // upper half of data space reads program memory bytes
   assign fword = pmem[dreq.addr[8:1]];
   assign dbyte = dreq.addr[15] ? (dreq.addr[0] ? fword[15:8] : fword[7:0])
                                : dmem[dreq.addr];
   // released bus shows the inverse of its last value
   assign drdata = dreq.rd ? dbyte : ~last;

   // writes land on the rising edge
   always @(posedge clk_sys)
   begin
      if (dreq.rd) last <= dbyte;
      if (dreq.wr && !dreq.addr[15]) dmem[dreq.addr] <= dreq.wdata;
   end
endmodule // cfa_mem_model
`default_nettype wire

/* tb/cpu_core_fetch_alu_memmap_tb.sv */
`default_nettype none
module cpu_core_fetch_alu_memmap_tb;
   import cfa_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] TOP = 16'h3FFF;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] fetch_addr, fetch_word, pgm_addr, pgm_word;
   logic [15:0] stack_pointer, fetch_word_held;
   logic [7:0]  drdata, alu_status_flags;
   logic        dec_valid = 1'b0;
   logic        stall;
   cfa_dec_t    dec = '0;
   cfa_dreq_t   dreq;
   cfa_region_t dregion;
   int          bad_count = 0;
   int          cmp_count = 0;

   always #5 clk_sys = ~clk_sys;

   cfa_core #(.SRAM_TOP(TOP)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .fetch_addr(fetch_addr), .fetch_word(fetch_word), .pgm_addr(pgm_addr),
      .pgm_word(pgm_word), .dec(dec), .dec_valid(dec_valid), .dreq(dreq),
      .dregion(dregion), .drdata(drdata), .alu_status_flags(alu_status_flags),
      .stack_pointer(stack_pointer), .fetch_word_held(fetch_word_held),
      .stall(stall));
   cfa_mem_model u_mem (.clk_sys(clk_sys), .fetch_addr(fetch_addr),
      .fetch_word(fetch_word), .pgm_addr(pgm_addr), .pgm_word(pgm_word),
      .dreq(dreq), .drdata(drdata));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   function automatic cfa_dec_t mk(cfa_op_t op, logic [4:0] r, logic [4:0] s,
                                   logic [7:0] imm, logic [15:0] a);
      mk = '0;
      mk.op = op;
      mk.rd = r;
      mk.rr = s;
      mk.use_imm = (op == CFA_OP_MOV);
      mk.imm = imm;
      mk.addr = a;
      mk.amode = CFA_AM_DIRECT;
   endfunction

   // present one instruction at the falling edge, holding while stalled
   task automatic exec(input cfa_dec_t d);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (stall === 1'b1 && n < 20)
      begin
         n++;
         @(negedge clk_sys);
      end
      dec = d;
      dec_valid = 1'b1;
      #1;
   endtask

   task automatic setr(input logic [4:0] r, input logic [7:0] v);
      exec(mk(CFA_OP_MOV, r, r, v, 16'h0000));
   endtask

   task automatic store_chk(input logic [4:0] r, input logic [7:0] v);
      exec(mk(CFA_OP_STORE, r, r, 8'h00, 16'h1900));
      chk(16'(dreq.wr), 16'h0001, "store strobe");
      chk(16'(dreq.wdata), 16'(v), "register value");
   endtask

   function automatic cfa_region_t region_of(logic [15:0] a);
      region_of.io_low = (a <= 16'h003F);
      region_of.io_ext = (a >= 16'h0040 && a <= 16'h0FFF);
      region_of.nvm    = (a >= 16'h1000 && a <= 16'h17FF);
      region_of.sram   = (a >= 16'h1800 && a <= 16'h7FFF);
      region_of.flash  = (a >= 16'h8000);
   endfunction

   // watchdog sized well beyond the expected run
   initial
   begin
      #200000;
      bad_count++;
      final_report();
   end

   initial
   begin
      logic [15:0] addrs [10] = '{16'h0000, 16'h003F, 16'h0040, 16'h0FFF, 16'h1000,
                                 16'h17FF, 16'h1800, 16'h7FFF, 16'h8000, 16'hFFFF};
      cfa_op_t     ops [5] = '{CFA_OP_ADD, CFA_OP_SUB, CFA_OP_AND, CFA_OP_OR, CFA_OP_EOR};
      logic [2:0]  modes [4] = '{3'b000, 3'b110, 3'b100, 3'b111};
      int          a, b, r, sa, sb, p;
      logic [7:0]  fl;
      logic [15:0] sp0, ra, q [$], qd [$];
      cfa_dec_t    md;
      void'($urandom(42));
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      sys_rst = 1'b0;
      #1;
      chk(fetch_addr, 16'h0000, "fetch after reset");
      chk(stack_pointer, TOP, "stack after reset");
      chk(16'(alu_status_flags), 16'h0000, "flags after reset");
      // fetch moves one word per edge since the release
      for (int i = 0; i < 5; i++) exec(mk(CFA_OP_NOP, 5'd0, 5'd0, 8'h00, 16'h0000));
      @(negedge clk_sys);
      dec_valid = 1'b0;
      #1;
      chk(fetch_addr, 16'h0006, "fetch advance");
      // data address map decode at region edges
      setr(5'd5, 8'h00);
      foreach (addrs[i])
      begin
         exec(mk(CFA_OP_STORE, 5'd5, 5'd5, 8'h00, addrs[i]));
         chk(dreq.addr, addrs[i], "store address");
         chk(16'(dregion), 16'(region_of(addrs[i])), "region decode");
      end
      // alu results and flags, boundary pairs then random
      for (int i = 0; i < 20; i++)
      begin
         a = (i == 0) ? 255 : (i == 1) ? 128 : int'($urandom % 256);
         b = (i == 0) ? 1 : (i == 1) ? 128 : int'($urandom % 256);
         setr(5'd2, 8'(a));
         setr(5'd3, 8'(b));
         exec(mk(ops[i % 5], 5'd2, 5'd3, 8'h00, 16'h0000));
         case (i % 5)
            0: r = a + b;
            1: r = a - b;
            2: r = a & b;
            3: r = a | b;
            default: r = a ^ b;
         endcase
         store_chk(5'd2, 8'(r));
         fl = alu_status_flags;
         chk(16'(fl[1]), 16'((r & 255) == 0), "zero flag");
         chk(16'(fl[2]), 16'((r >> 7) & 1), "negative flag");
         if (i % 5 < 2) chk(16'(fl[0]), 16'(r < 0 || r > 255), "carry flag");
         if (i % 5 >= 2) chk(16'(fl[3]), 16'h0000, "logic overflow");
         if (i % 5 == 0)
         begin
            chk(16'(fl[5]), 16'((a % 16) + (b % 16) > 15), "half carry");
            p = ((a >> 7) == (b >> 7)) && (((r >> 7) & 1) != (a >> 7));
            chk(16'(fl[3]), 16'(p), "overflow flag");
            chk(16'(fl[4]), 16'(p ^ ((r >> 7) & 1)), "sign flag");
         end
      end
      // multiplier unsigned, signed, signed-by-unsigned and signed fractional
      for (int i = 0; i < 8; i++)
      begin
         a = int'($urandom % 256);
         b = int'($urandom % 256);
         setr(5'd16, 8'(a));
         setr(5'd17, 8'(b));
         md = mk(CFA_OP_MUL, 5'd16, 5'd17, 8'h00, 16'h0000);
         md.mul = modes[i % 4];
         exec(md);
         sa = (modes[i % 4][2] && a > 127) ? a - 256 : a;
         sb = (modes[i % 4][1] && b > 127) ? b - 256 : b;
         p = modes[i % 4][0] ? (sa * sb) * 2 : sa * sb;
         store_chk(5'd0, 8'(p));
         store_chk(5'd1, 8'(p >> 8));
      end
      // program-memory load takes the word address from the Z pair
      setr(5'd30, 8'h34);
      setr(5'd31, 8'h12);
      exec(mk(CFA_OP_PGM_LOAD, 5'd4, 5'd0, 8'h00, 16'h0000));
      chk(pgm_addr, 16'h091A, "program load address");
      store_chk(5'd4, 8'h4F);
      // call pushes two bytes downward, return restores the pointer
      sp0 = stack_pointer;
      exec(mk(CFA_OP_CALL, 5'd0, 5'd0, 8'h00, 16'h0123));
      ra = fetch_addr;
      for (int k = 0; k < 4; k++)
      begin
         @(negedge clk_sys);
         if (stall !== 1'b1) dec_valid = 1'b0;
         #1;
         if (k == 0) chk(fetch_addr, 16'h0123, "call target");
         if (dreq.wr === 1'b1) q.push_back(dreq.addr);
         if (dreq.wr === 1'b1) qd.push_back(16'(dreq.wdata));
      end
      chk(16'(q.size()), 16'h0002, "push count");
      if (q.size() == 2) chk(q[0], sp0, "low byte address");
      if (q.size() == 2) chk(q[1], sp0 - 16'h0001, "high byte address");
      if (q.size() == 2) chk(qd[0], 16'(ra[7:0]), "low byte pushed");
      if (q.size() == 2) chk(qd[1], 16'(ra[15:8]), "high byte pushed");
      chk(stack_pointer, sp0 - 16'h0002, "stack after call");
      exec(mk(CFA_OP_RET, 5'd0, 5'd0, 8'h00, 16'h0000));
      for (int k = 0; k < 3; k++)
      begin
         @(negedge clk_sys);
         if (stall !== 1'b1) dec_valid = 1'b0;
         #1;
         if (k == 1) chk(fetch_addr, ra, "return target");
      end
      chk(stack_pointer, sp0, "stack after return");
      final_report();
   end
endmodule // cpu_core_fetch_alu_memmap_tb
`default_nettype wire
